// *** rtl/psm_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * power save mode controller.
 * Assumes inclusion by bare name from the package, the controller and the core model.
 */
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH

`define PSM_ADDR_W            4
`define PSM_DATA_W            16
`define PSM_OFF_CONTROL       4'h0
`define PSM_OFF_WAKE_FLAGS    4'h1
`define PSM_OFF_RETENTION_0   4'h2
`define PSM_OFF_RETENTION_1   4'h3
`define PSM_OFF_STATUS        4'h4
`define PSM_OFF_IRQ_FLAGS     4'h5
`define PSM_OFF_IRQ_MASK      4'h6
`define PSM_BIT_ARM           15
`define PSM_BIT_RELEASE       0
`define PSM_WAKE_POR          0
`define PSM_WAKE_MASTER_CLEAR_PIN         1
`define PSM_WAKE_ALARM        2
`define PSM_WAKE_EXT0         3
`define PSM_WAKE_LPWDT        4
`define PSM_WAKE_BOR          5
`define PSM_IRQ_IDLE_WAKE     0
`define PSM_IRQ_DEEP_WAKE     1
`define PSM_IRQ_ARM_TIMEOUT   2
`define PSM_RESET_WORD        16'h0000
`define PSM_INSTR_CYCLE_NS    20
`define PSM_CLK_NS            10
`define PSM_ARM_WINDOW_TCY    3
`define PSM_ARM_WINDOW_CLKS   ((`PSM_ARM_WINDOW_TCY * `PSM_INSTR_CYCLE_NS) / `PSM_CLK_NS)

`endif

// *** rtl/psm_pkg.sv ***
/*
 * Types of the power save mode controller.
 * Assumes psm_regs.svh is on the include path.
 */
`include "psm_regs.svh"

package psm_pkg;

    typedef enum logic [3:0] {
        PSM_RUN   = 4'h1,
        PSM_ENTER = 4'h2,
        PSM_IDLE  = 4'h4,
        PSM_DEEP  = 4'h8
    } psm_state_type;

    typedef logic [`PSM_DATA_W-1:0] psm_word_type;

endpackage

// *** rtl/psm_ctrl.sv ***
/*
 * Power save mode controller: Idle and Deep Sleep sequencing, arm window,
 * wake-cause capture, retention words and an interrupt on wake events.
 * Assumes the core raises power_save_instr for one cycle with its operand,
 * and that pin and oscillator inputs are asynchronous to core_clk.
 */
`timescale 1ns/1ps
`include "psm_regs.svh"

module psm_ctrl (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    // Register port
    input  wire logic [`PSM_ADDR_W-1:0] reg_addr,
    input  wire logic [`PSM_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    output logic      [`PSM_DATA_W-1:0] reg_rdata,
    // Core side
    input  wire logic                   power_save_instr,
    input  wire logic                   power_save_deep,
    input  wire logic                   irq_pending,
    input  wire logic                   device_reset,
    output logic                        cpu_halt,
    output logic                        cpu_resume,
    // Watchdogs, oscillator and regulator
    input  wire logic                   watchdog_enable,
    input  wire logic                   clock_fail_monitor_en,
    input  wire logic                   watchdog_timeout,
    input  wire logic                   internal_regulator_en,
    input  wire logic                   low_power_brownout_cfg,
    output logic                        watchdog_clear,
    output logic                        low_power_rc_osc_en,
    output logic                        core_supply_regulator_off,
    output logic                        low_power_watchdog_run,
    output logic                        low_power_brownout_en,
    output logic                        calendar_clock_keep,
    output logic                        system_clock_on,
    // Asynchronous wake pins
    input  wire logic                   por_event,
    input  wire logic                   master_clear_pin,
    input  wire logic                   calendar_clock_alarm,
    input  wire logic                   ext_int0,
    input  wire logic                   low_power_watchdog,
    input  wire logic                   low_power_brownout_reset,
    // Interrupt
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a level counts once stages two and
    // three agree, so stage one feeds nothing but stage two.
    localparam int NPIN = 6;
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [NPIN-1:0] pin_s3;
    logic [NPIN-1:0] pin_lvl;
    wire  [NPIN-1:0] pin_raw = {low_power_brownout_reset, low_power_watchdog, ext_int0,
                                calendar_clock_alarm, master_clear_pin, por_event};
    wire  [NPIN-1:0] next_pin_lvl = (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pin_s1  <= '0;
            pin_s2  <= '0;
            pin_s3  <= '0;
            pin_lvl <= '0;
        end else begin
            pin_s1  <= pin_raw;
            pin_s2  <= pin_s1;
            pin_s3  <= pin_s2;
            pin_lvl <= next_pin_lvl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    localparam logic [2:0] WIN_CLKS = 3'(`PSM_ARM_WINDOW_CLKS);
    psm_pkg::psm_state_type state;
    psm_pkg::psm_word_type  retention_word_0;
    psm_pkg::psm_word_type  retention_word_1;
    logic [5:0]             wake_cause_flags;
    logic                   deep_sleep_arm;
    logic                   release_hold;
    logic [2:0]             arm_count;
    logic [2:0]             irq_flags;
    logic [2:0]             irq_mask;
    logic                   deferred_irq;

    function automatic logic hit(input logic [`PSM_ADDR_W-1:0] off);
        hit = (reg_addr == off);
    endfunction

    wire wr_ctrl  = reg_write && hit(`PSM_OFF_CONTROL);
    wire wr_ret0  = reg_write && hit(`PSM_OFF_RETENTION_0);
    wire wr_ret1  = reg_write && hit(`PSM_OFF_RETENTION_1);
    wire wr_iflg  = reg_write && hit(`PSM_OFF_IRQ_FLAGS);
    wire wr_imsk  = reg_write && hit(`PSM_OFF_IRQ_MASK);
    wire arm_set  = wr_ctrl && reg_wdata[`PSM_BIT_ARM] && !deep_sleep_arm;

    // Deep entry needs arm and the internal regulator.
    wire deep_go  = power_save_instr && power_save_deep && deep_sleep_arm
                    && internal_regulator_en;
    wire idle_go  = power_save_instr && !power_save_deep;

    // Only the listed events may end Deep Sleep; brown-out only if configured.
    wire [5:0] deep_wake = {pin_lvl[5] & low_power_brownout_cfg,
                            pin_lvl[4:0]};
    wire deep_exit = (state == psm_pkg::PSM_DEEP) && (|deep_wake);
    wire idle_exit = (state == psm_pkg::PSM_IDLE)
                     && (irq_pending || deferred_irq || device_reset
                         || watchdog_timeout);
    wire arm_expire = deep_sleep_arm && (arm_count == WIN_CLKS) && !deep_go;
    wire [2:0] irq_evt = {arm_expire, deep_exit, idle_exit};

    ////////////////////////////////////////////////////////////////////////
    // Mode sequencer.
    psm_pkg::psm_state_type next_state;
    always_comb begin
        next_state = state;
        case (state)
            psm_pkg::PSM_RUN: begin
                if (deep_go) next_state = psm_pkg::PSM_DEEP;
                else if (idle_go) next_state = psm_pkg::PSM_ENTER;
            end
            // One cycle to finish entry; interrupts seen here are held off.
            psm_pkg::PSM_ENTER: next_state = psm_pkg::PSM_IDLE;
            psm_pkg::PSM_IDLE: if (idle_exit) next_state = psm_pkg::PSM_RUN;
            psm_pkg::PSM_DEEP: if (deep_exit) next_state = psm_pkg::PSM_RUN;
            default: next_state = psm_pkg::PSM_RUN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state <= psm_pkg::PSM_RUN;
        end else begin
            state <= next_state;
        end
    end

    // An interrupt seen while entry finishes is kept until the core runs again.
    wire next_deferred_irq = (state == psm_pkg::PSM_ENTER) ? irq_pending
                             : (deferred_irq && state != psm_pkg::PSM_RUN);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            deferred_irq <= 1'b0;
        end else begin
            deferred_irq <= next_deferred_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control, arm window, wake flags and retention.
    // The arm bit drops on entry, on exit and when its window runs out.
    wire       next_arm_clear = deep_exit || arm_expire || deep_go;
    wire [2:0] next_arm_count = (deep_sleep_arm && !arm_set)
                                ? arm_count + 3'h1 : 3'h0;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            deep_sleep_arm <= 1'b0;
        end else if (next_arm_clear) begin
            deep_sleep_arm <= 1'b0;
        end else if (arm_set) begin
            deep_sleep_arm <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            arm_count <= 3'h0;
        end else begin
            arm_count <= next_arm_count;
        end
    end

    // A Deep Sleep exit raises release, so pins stay held until software lets go.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            release_hold <= 1'b0;
        end else if (deep_exit) begin
            release_hold <= 1'b1;
        end else if (wr_ctrl) begin
            release_hold <= reg_wdata[`PSM_BIT_RELEASE];
        end
    end

    // An exit load beats an arm clear, though software cannot arm while asleep.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wake_cause_flags <= 6'h00;
        end else if (deep_exit) begin
            wake_cause_flags <= deep_wake;
        end else if (arm_set) begin
            wake_cause_flags <= 6'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            retention_word_0 <= `PSM_RESET_WORD;
        end else if (wr_ret0) begin
            retention_word_0 <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            retention_word_1 <= `PSM_RESET_WORD;
        end else if (wr_ret1) begin
            retention_word_1 <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt flags: set beats a write-one clear in the same cycle.
    wire [2:0] irq_clear      = wr_iflg ? reg_wdata[2:0] : 3'h0;
    wire [2:0] next_irq_flags = irq_evt | (irq_flags & ~irq_clear);
    wire       next_irq       = |(irq_flags & irq_mask);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq_flags <= 3'h0;
        end else begin
            irq_flags <= next_irq_flags;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq_mask <= 3'h0;
        end else if (wr_imsk) begin
            irq_mask <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, zero elsewhere.
    wire [`PSM_DATA_W-1:0] rd_mux =
        hit(`PSM_OFF_CONTROL)     ? {deep_sleep_arm, 14'h0000, release_hold} :
        hit(`PSM_OFF_WAKE_FLAGS)  ? {10'h000, wake_cause_flags} :
        hit(`PSM_OFF_RETENTION_0) ? retention_word_0 :
        hit(`PSM_OFF_RETENTION_1) ? retention_word_1 :
        hit(`PSM_OFF_STATUS)      ? {12'h000, state} :
        hit(`PSM_OFF_IRQ_FLAGS)   ? {13'h0000, irq_flags} :
        hit(`PSM_OFF_IRQ_MASK)    ? {13'h0000, irq_mask} : 16'h0000;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_read ? rd_mux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered.
    wire in_idle = (next_state == psm_pkg::PSM_ENTER) || (next_state == psm_pkg::PSM_IDLE);
    wire in_deep = (next_state == psm_pkg::PSM_DEEP);

    // Next values; each output then has a short register of its own.
    wire next_cpu_halt       = in_idle || in_deep;
    wire next_cpu_resume     = idle_exit || deep_exit;
    wire next_watchdog_clear = (state == psm_pkg::PSM_RUN) && idle_go && !deep_go;
    // The RC oscillator is off in reset, and otherwise may only stop in Idle with both of its users off.
    wire next_rc_osc_en      = !in_idle || watchdog_enable
                               || clock_fail_monitor_en || in_deep;
    wire next_sysclk_on      = !in_deep;
    wire next_regulator_off  = in_deep;
    wire next_lp_wdt_run     = in_deep;
    wire next_lp_bor_en      = in_deep && low_power_brownout_cfg;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cpu_halt <= 1'b0;
        end else begin
            cpu_halt <= next_cpu_halt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cpu_resume <= 1'b0;
        end else begin
            cpu_resume <= next_cpu_resume;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            watchdog_clear <= 1'b0;
        end else begin
            watchdog_clear <= next_watchdog_clear;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            low_power_rc_osc_en <= 1'b0;
        end else begin
            low_power_rc_osc_en <= next_rc_osc_en;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            system_clock_on <= 1'b1;
        end else begin
            system_clock_on <= next_sysclk_on;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            core_supply_regulator_off <= 1'b0;
        end else begin
            core_supply_regulator_off <= next_regulator_off;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            low_power_watchdog_run <= 1'b0;
        end else begin
            low_power_watchdog_run <= next_lp_wdt_run;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            low_power_brownout_en <= 1'b0;
        end else begin
            low_power_brownout_en <= next_lp_bor_en;
        end
    end

    // The calendar clock keeps its supply whatever the mode; reset alone clears the hold.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            calendar_clock_keep <= 1'b0;
        end else begin
            calendar_clock_keep <= 1'b1;
        end
    end

endmodule

// *** bench/psm_ctrl_props.sv ***
/* Concurrent checks on the ports of psm_ctrl.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module psm_ctrl_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Core side
    input wire logic power_save_instr,
    input wire logic power_save_deep,
    input wire logic cpu_halt,
    input wire logic cpu_resume,
    // Power control
    input wire logic watchdog_enable,
    input wire logic internal_regulator_en,
    input wire logic low_power_brownout_cfg,
    input wire logic ext_int0,
    input wire logic watchdog_clear,
    input wire logic low_power_rc_osc_en,
    input wire logic core_supply_regulator_off,
    input wire logic low_power_watchdog_run,
    input wire logic low_power_brownout_en,
    input wire logic system_clock_on
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
////////////////////////////////
    a_resume_ends_halt: assert property (cpu_resume |-> !cpu_halt && $past(cpu_halt))
        else $error("resume without halt ending");
    a_resume_one_pulse: assert property (cpu_resume |=> !cpu_resume)
        else $error("resume pulse too long");
    a_idle_clears_wdog: assert property (
        power_save_instr && !power_save_deep && !cpu_halt |=> watchdog_clear && cpu_halt)
        else $error("idle entry without halt and clear");
    a_sysclk_deep_only: assert property (system_clock_on != core_supply_regulator_off)
        else $error("system clock wrong for mode");
    a_low_power_rc_osc_in_idle: assert property (
        cpu_halt && !core_supply_regulator_off && $past(watchdog_enable)
        |-> low_power_rc_osc_en)
        else $error("rc oscillator off in idle");
    a_deep_needs_reg: assert property ($rose(core_supply_regulator_off) |->
        internal_regulator_en && ($past(power_save_instr) || $past(power_save_instr, 2)))
        else $error("deep entry without cause");
    a_bor_cfg_gate: assert property (
        low_power_brownout_en == (core_supply_regulator_off && $past(low_power_brownout_cfg)))
        else $error("brownout enable wrong");
    a_lpwdt_in_deep: assert property (low_power_watchdog_run == core_supply_regulator_off)
        else $error("deep watchdog run wrong");
    a_ext0_wakes: assert property (
        $rose(ext_int0) && core_supply_regulator_off |-> ##[1:10] cpu_resume)
        else $error("no wake from ext int");
endmodule

bind psm_ctrl psm_ctrl_props i_props (
    .core_clk, .resetn, .power_save_instr, .power_save_deep, .cpu_halt, .cpu_resume,
    .watchdog_enable, .internal_regulator_en, .low_power_brownout_cfg, .ext_int0,
    .watchdog_clear, .low_power_rc_osc_en, .core_supply_regulator_off,
    .low_power_watchdog_run, .low_power_brownout_en, .system_clock_on
);

// *** bench/psm_core_model.sv ***
/* Processor core model issuing power-save instructions.
   Assumes the testbench calls its tasks after reset. */
`timescale 1ns/1ps
`include "psm_regs.svh"
module psm_core_model (
    // Clock
    input  wire logic core_clk,
    // Instruction issue
    output logic      power_save_instr,
    output logic      power_save_deep
);
    initial power_save_instr = 1'b0;
    initial power_save_deep = 1'b0;
////////////////////////////////
    // A large gap plays a slow core that misses the arm window.
    task automatic issue(input logic deep, input int gap);
        repeat (gap) @(posedge core_clk);
        @(posedge core_clk);
        power_save_instr <= 1'b1;
        power_save_deep <= deep;
        @(posedge core_clk);
        power_save_instr <= 1'b0;
    endtask
    task automatic rest();
        repeat (`PSM_ARM_WINDOW_CLKS + 1) @(posedge core_clk);
    endtask
endmodule

// *** bench/tb.sv ***
/* Self-checking testbench of psm_ctrl.
   Assumes the core model and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        irq_pending = 1'b0;
    logic        watchdog_timeout = 1'b0;
    logic        device_reset = 1'b0;
    logic        clock_fail_monitor_en = 1'b0;
    logic        watchdog_enable = 1'b1;
    logic        internal_regulator_en = 1'b1;
    logic        low_power_brownout_cfg = 1'b1;
    logic [5:0]  wp = 6'h00;
    wire  [15:0] reg_rdata;
    wire         power_save_instr, power_save_deep, cpu_halt, cpu_resume, watchdog_clear;
    wire         low_power_rc_osc_en, core_supply_regulator_off, low_power_watchdog_run;
    wire         low_power_brownout_en, calendar_clock_keep, system_clock_on, irq;
    int          err_total = 0;
    int          total_checks = 0;
    always #5 core_clk = ~core_clk;
    psm_core_model i_core (.core_clk, .power_save_instr, .power_save_deep);
    psm_ctrl i_dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .power_save_instr, .power_save_deep, .irq_pending, .device_reset,
        .cpu_halt, .cpu_resume, .watchdog_enable, .clock_fail_monitor_en,
        .watchdog_timeout, .internal_regulator_en, .low_power_brownout_cfg, .watchdog_clear,
        .low_power_rc_osc_en, .core_supply_regulator_off, .low_power_watchdog_run,
        .low_power_brownout_en, .calendar_clock_keep, .system_clock_on, .por_event(wp[0]),
        .master_clear_pin(wp[1]), .calendar_clock_alarm(wp[2]), .ext_int0(wp[3]),
        .low_power_watchdog(wp[4]), .low_power_brownout_reset(wp[5]), .irq);
////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // The pulse lasts one cycle, so it is looked for after every edge.
    task automatic wait_resume();
        int n;
        n = 0;
        while (cpu_resume !== 1'b1 && n < 12) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk(16'(cpu_resume), 16'h0001);
        chk(16'(cpu_halt), 16'h0000);
    endtask
    task automatic t_reset();
        rd(4'h4, 16'h0001);
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0000);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        wr(4'h4, 16'hFFFF);
        rd(4'h4, 16'h0001);
        wr(4'h2, 16'hA5C3);
        wr(4'h3, 16'h5A3C);
        rd(4'h2, 16'hA5C3);
        rd(4'h3, 16'h5A3C);
        chk(16'(calendar_clock_keep), 16'h0001);
        $display("test reset done");
    endtask
    task automatic t_idle(input int mode);
        @(posedge core_clk);
        irq_pending <= (mode == 2);
        watchdog_enable <= (mode == 1) || (mode == 2);
        clock_fail_monitor_en <= (mode == 3);
        i_core.issue(1'b0, 0);
        #1 chk(16'(watchdog_clear), 16'h0001);
        chk(16'(cpu_halt), 16'h0001);
        chk(16'(system_clock_on), 16'h0001);
        chk(16'(low_power_rc_osc_en), 16'(mode != 0));
        if (mode != 2) begin
            repeat (4) @(posedge core_clk);
            irq_pending <= (mode == 0);
            watchdog_timeout <= (mode == 1);
            device_reset <= (mode == 3);
            #1 chk(16'(cpu_halt), 16'h0001);
        end
        wait_resume();
        @(posedge core_clk);
        irq_pending <= 1'b0;
        watchdog_timeout <= 1'b0;
        device_reset <= 1'b0;
        watchdog_enable <= 1'b1;
        clock_fail_monitor_en <= 1'b0;
        $display("test idle done");
    endtask
    task automatic t_irq();
        rd(4'h5, 16'h0001);
        chk(16'(irq), 16'h0000);
        wr(4'h6, 16'h0001);
        repeat (2) @(posedge core_clk);
        #1 chk(16'(irq), 16'h0001);
        wr(4'h5, 16'h0001);
        repeat (2) @(posedge core_clk);
        #1 chk(16'(irq), 16'h0000);
        wr(4'h6, 16'h0007);
        $display("test irq done");
    endtask
    task automatic t_arm(input logic reg_on);
        internal_regulator_en <= reg_on;
        wr(4'h0, 16'h8000);
        rd(4'h0, 16'h8000);
        i_core.issue(1'b1, reg_on ? 8 : 0);
        repeat (10) @(posedge core_clk);
        #1 chk(16'(core_supply_regulator_off), 16'h0000);
        rd(4'h0, 16'h0000);
        rd(4'h5, 16'h0004);
        chk(16'(irq), 16'h0001);
        wr(4'h5, 16'h0004);
        internal_regulator_en <= 1'b1;
        $display("test arm done");
    endtask
    task automatic t_deep(input int idx);
        wr(4'h0, 16'h8000);
        rd(4'h1, 16'h0000);
        i_core.issue(1'b1, 0);
        rd(4'h4, 16'h0008);
        chk(16'(core_supply_regulator_off), 16'h0001);
        chk(16'(low_power_brownout_en), 16'h0001);
        chk(16'(low_power_watchdog_run), 16'h0001);
        chk(16'(system_clock_on), 16'h0000);
        @(posedge core_clk);
        irq_pending <= 1'b1;
        watchdog_timeout <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1 chk(16'(cpu_halt), 16'h0001);
        @(posedge core_clk);
        wp[idx] <= 1'b1;
        wait_resume();
        @(posedge core_clk);
        wp[idx] <= 1'b0;
        irq_pending <= 1'b0;
        watchdog_timeout <= 1'b0;
        rd(4'h1, 16'h0001 << idx);
        rd(4'h0, 16'h0001);
        rd(4'h2, 16'hA5C3);
        wr(4'h0, 16'h0000);
        i_core.rest();
        $display("test deep done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        for (int m = 0; m < 4; m++) t_idle(m);
        t_irq();
        t_arm(1'b1);
        t_arm(1'b0);
        for (int i = 0; i < 6; i++) t_deep(i);
        end_sim();
    end
endmodule
